// file: verilog/deac_params.svh
`ifndef DEAC_PARAMS_SVH
`define DEAC_PARAMS_SVH

// register byte offsets on the bus
`define DEAC_OFF_DATA 8'h00
`define DEAC_OFF_LOCATION 8'h04
`define DEAC_OFF_CONTROL 8'h08
`define DEAC_OFF_UNLOCK 8'h0c
`define DEAC_OFF_FLAGS 8'h10

// control register fields
`define DEAC_RD_BIT 0
`define DEAC_WR_BIT 1
`define DEAC_PERMIT_BIT 2
`define DEAC_ABORT_BIT 3
// peripheral flag register field
`define DEAC_DONE_BIT 7

// reset values
`define DEAC_DATA_RST 8'h00
`define DEAC_LOCATION_RST 8'h00

// unlock keys and erased byte
`define DEAC_KEY_FIRST 8'h55
`define DEAC_KEY_SECOND 8'haa
`define DEAC_ERASED 8'hff

// timing
`define DEAC_CLK_MHZ 100
`define DEAC_PWRT_MS 64
`define DEAC_PWRT_CYCLES (`DEAC_PWRT_MS * 1000 * `DEAC_CLK_MHZ)
`define DEAC_PROG_CYCLES 500
`define DEAC_UNLOCK_WINDOW 16

// bus responses
`define DEAC_RESP_OKAY 2'b00
`define DEAC_RESP_SLVERR 2'b10

`endif

// file: verilog/deac_pkg.sv
`default_nettype none
package deac_pkg;
    typedef enum logic [2:0] {
        PS_IDLE = 3'b001,
        PS_ERASE = 3'b010,
        PS_PROG = 3'b100
    } deac_prog_t;

    typedef enum logic [2:0] {
        ARM_NONE = 3'b001,
        ARM_FIRST = 3'b010,
        ARM_SECOND = 3'b100
    } deac_arm_t;
endpackage : deac_pkg
`default_nettype wire

// file: verilog/deac_mem.sv
`timescale 1ns/1ns
`default_nettype none
module deac_mem #(
    parameter int DW = 8,
    parameter int AW = 8
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr_a,
    output logic [DW-1:0] rdata_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [DW-1:0] rdata_b
);
    logic [DW-1:0] cells [0:(1<<AW)-1];

    // one write port, two registered read ports
    always_ff @(posedge clk) begin
        if (we) begin
            cells[waddr] <= wdata;
        end
        rdata_a <= cells[raddr_a];
        rdata_b <= cells[raddr_b];
    end
endmodule : deac_mem
`default_nettype wire

// file: verilog/deac_ctrl.sv
// What this block does
// R1: 256 byte locations, addressed 00h..ffh by the location register.
// R2: data register is 8 bits: byte to program or byte fetched.
// R3: each byte write erases the location, then programs the new byte.
// R4: an internal timer paces and ends every write not cut by a reset.
// R5: protection on: core access normal, external programmer reads zeros.
// R6: control bits 7..4 read zero; only four low bits exist.
// R7: read/write start bits set by software only, cleared by hardware.
// R8: write permit bit 2 allows writes; cleared on power-up.
// R9: abort flag bit 3 set when a reset cuts a write; 0 on completion.
// R10: a reset during a write clears data and location registers.
// R11: write completion sets the done flag until software clears it.
// R12: unlock port has no storage, reads zero, only arms writes.
// R13: software keeps control, data, location unchanged while writing.
// R14: read start bit 0 loads the addressed byte by the next cycle.
// R15: data register keeps fetched byte until next read or write.
// R16: write start bit 1 starts a write; reads 1 until done.
// R17: write starts only after 55h, aah, then write start, in order.
// R18: write start ignored while write permit is 0.
// R19: clearing permit mid-write has no effect; hardware clears it only on a reset.
// R20: no array writes while the 64 ms power-up timer runs.
// R21: program time is a counter with a parameter terminal count.
`timescale 1ns/1ns
`default_nettype none
`include "deac_params.svh"
module deac_ctrl import deac_pkg::*; #(
    parameter int PWRT_CYCLES = `DEAC_PWRT_CYCLES,
    parameter int PROG_CYCLES = `DEAC_PROG_CYCLES,
    parameter int UNLOCK_WINDOW = `DEAC_UNLOCK_WINDOW
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_reset_pin,
    input wire logic watchdog_timeout,
    input wire logic brownout_reset,
    input wire logic data_protect,
    input wire logic [7:0] prog_addr,
    output logic [7:0] prog_rdata,
    output logic store_done_flag,
    output logic store_busy
);
    localparam int ERASE_CYCLES = (PROG_CYCLES / 2 > 0) ? PROG_CYCLES / 2 : 1;
    localparam int WRITE_CYCLES =
        (PROG_CYCLES - ERASE_CYCLES > 0) ? PROG_CYCLES - ERASE_CYCLES : 1;

    // input synchronisers
    logic [11:0] sync_a;
    logic [11:0] sync_b;
    logic reset_event;
    logic protect_s;
    logic [7:0] prog_addr_s;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync_a <= 12'h000;
            sync_b <= 12'h000;
        end else begin
            sync_a <= {prog_addr, data_protect, brownout_reset,
                       watchdog_timeout, external_reset_pin};
            sync_b <= sync_a;
        end
    end

    assign reset_event = |sync_b[2:0];
    assign protect_s = sync_b[3];
    assign prog_addr_s = sync_b[11:4];

    // bus slave state
    logic aw_got, next_aw_got;
    logic w_got, next_w_got;
    logic [7:0] awaddr_q, next_awaddr_q;
    logic [7:0] wdata_q, next_wdata_q;
    logic strb_q, next_strb_q;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [1:0] rresp, next_rresp;
    logic [31:0] rdata, next_rdata;

    // block state
    logic [7:0] data_byte, next_data_byte;
    logic [7:0] location, next_location;
    logic rd_start, next_rd_start;
    logic permit, next_permit;
    logic abort, next_abort;
    logic done, next_done;
    deac_arm_t arm, next_arm;
    logic [31:0] arm_cnt, next_arm_cnt;
    deac_prog_t pstate, next_pstate;
    logic [31:0] pcnt, next_pcnt;
    logic [31:0] pwrt_cnt, next_pwrt_cnt;
    logic [7:0] prog_q, next_prog_q;

    logic reg_wr;
    logic [7:0] wr_addr;
    logic [7:0] wr_byte;
    logic wr_lane;
    logic wr_mapped;
    logic rd_mapped;
    logic [7:0] rd_byte;
    logic busy;
    logic pwrt_done;
    logic mem_we;
    logic [7:0] mem_din;
    logic [7:0] mem_rdata_a;
    logic [7:0] mem_rdata_b;

    assign busy = (pstate != PS_IDLE);
    assign pwrt_done = (pwrt_cnt == 32'(PWRT_CYCLES));
    assign s_axi_awready = !aw_got && !bvalid;
    assign s_axi_wready = !w_got && !bvalid;
    assign s_axi_arready = !rvalid;

    always_comb begin
        wr_addr = aw_got ? awaddr_q : s_axi_awaddr;
        wr_byte = w_got ? wdata_q : s_axi_wdata[7:0];
        wr_lane = w_got ? strb_q : s_axi_wstrb[0];
        reg_wr = (aw_got || s_axi_awvalid) && (w_got || s_axi_wvalid)
                 && !bvalid;
        case (wr_addr)
            `DEAC_OFF_DATA, `DEAC_OFF_LOCATION, `DEAC_OFF_CONTROL,
            `DEAC_OFF_UNLOCK, `DEAC_OFF_FLAGS: wr_mapped = 1'b1;
            default: wr_mapped = 1'b0;
        endcase
        rd_mapped = 1'b1;
        case (s_axi_araddr)
            `DEAC_OFF_DATA: rd_byte = data_byte;
            `DEAC_OFF_LOCATION: rd_byte = location;
            `DEAC_OFF_CONTROL: rd_byte = {4'h0, abort, permit, busy,
                                          rd_start}; // R6 R16
            `DEAC_OFF_UNLOCK: rd_byte = 8'h00; // R12
            `DEAC_OFF_FLAGS: rd_byte = {done, 7'h00};
            default: begin
                rd_byte = 8'h00;
                rd_mapped = 1'b0;
            end
        endcase
    end

    // bus slave next state
    always_comb begin
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_awaddr_q = awaddr_q;
        next_wdata_q = wdata_q;
        next_strb_q = strb_q;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_got = 1'b1;
            next_awaddr_q = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_got = 1'b1;
            next_wdata_q = s_axi_wdata[7:0];
            next_strb_q = s_axi_wstrb[0];
        end
        if (reg_wr) begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_mapped ? `DEAC_RESP_OKAY : `DEAC_RESP_SLVERR;
        end else if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata = {24'h000000, rd_byte};
            next_rresp = rd_mapped ? `DEAC_RESP_OKAY : `DEAC_RESP_SLVERR;
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 8'h00;
            strb_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `DEAC_RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= `DEAC_RESP_OKAY;
            rdata <= 32'h00000000;
        end else begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            awaddr_q <= next_awaddr_q;
            wdata_q <= next_wdata_q;
            strb_q <= next_strb_q;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
        end
    end

    // block next state
    always_comb begin
        next_data_byte = data_byte;
        next_location = location;
        next_rd_start = rd_start;
        next_permit = permit;
        next_abort = abort;
        next_done = done;
        next_arm = arm;
        next_arm_cnt = arm_cnt;
        next_pstate = pstate;
        next_pcnt = pcnt;
        next_pwrt_cnt = pwrt_done ? pwrt_cnt : pwrt_cnt + 32'h00000001; // R20
        next_prog_q = protect_s ? 8'h00 : mem_rdata_b; // R5
        mem_we = 1'b0;
        mem_din = data_byte;
        // unlock sequence lapses after a short window
        if (arm != ARM_NONE) begin
            next_arm_cnt = arm_cnt + 32'h00000001;
            if (arm_cnt >= 32'(UNLOCK_WINDOW - 1)) begin
                next_arm = ARM_NONE; // R17
            end
        end
        if (rd_start) begin
            next_data_byte = mem_rdata_a; // R14 R15
            next_rd_start = 1'b0; // R7 R14
        end
        case (pstate)
            PS_IDLE: begin
            end
            PS_ERASE: begin
                mem_we = (pcnt == 32'h00000000); // R3
                mem_din = `DEAC_ERASED;
                next_pcnt = pcnt + 32'h00000001;
                if (pcnt >= 32'(ERASE_CYCLES - 1)) begin // R4 R21
                    next_pstate = PS_PROG;
                    next_pcnt = 32'h00000000;
                end
            end
            PS_PROG: begin
                next_pcnt = pcnt + 32'h00000001;
                if (pcnt >= 32'(WRITE_CYCLES - 1)) begin // R4 R21
                    mem_we = 1'b1; // R3 R13
                    next_pstate = PS_IDLE; // R7 R16
                    next_done = 1'b1; // R11
                    next_abort = 1'b0; // R9
                end
            end
            default: next_pstate = PS_IDLE;
        endcase
        if (reg_wr && wr_lane && wr_mapped) begin
            next_arm = ARM_NONE; // R17
            next_arm_cnt = 32'h00000000;
            case (wr_addr)
                `DEAC_OFF_DATA: next_data_byte = wr_byte; // R2 R15
                `DEAC_OFF_LOCATION: next_location = wr_byte; // R1
                `DEAC_OFF_CONTROL: begin
                    if (wr_byte[`DEAC_RD_BIT]) begin
                        next_rd_start = 1'b1; // R7 R14
                    end
                    if (wr_byte[`DEAC_WR_BIT] && arm == ARM_SECOND
                        && permit && pwrt_done && !busy) begin // R17 R18 R20
                        next_pstate = PS_ERASE; // R16
                        next_pcnt = 32'h00000000;
                    end
                    next_permit = wr_byte[`DEAC_PERMIT_BIT]; // R8 R19
                    next_abort = wr_byte[`DEAC_ABORT_BIT];
                end
                `DEAC_OFF_UNLOCK: begin
                    if (wr_byte == `DEAC_KEY_FIRST) begin
                        next_arm = ARM_FIRST; // R12 R17
                    end else if (wr_byte == `DEAC_KEY_SECOND
                                 && arm == ARM_FIRST) begin
                        next_arm = ARM_SECOND; // R17
                    end
                end
                `DEAC_OFF_FLAGS: begin
                    if (!wr_byte[`DEAC_DONE_BIT]) begin
                        next_done = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // a completion in the same cycle as a clear still sets the flag
        if (pstate == PS_PROG && pcnt >= 32'(WRITE_CYCLES - 1)) begin
            next_done = 1'b1; // R11
        end
        if (reset_event) begin
            next_abort = abort | busy; // R9
            next_data_byte = `DEAC_DATA_RST; // R10
            next_location = `DEAC_LOCATION_RST; // R10
            next_rd_start = 1'b0;
            next_permit = 1'b0;
            next_arm = ARM_NONE;
            next_pstate = PS_IDLE;
            next_pcnt = 32'h00000000;
            mem_we = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            data_byte <= `DEAC_DATA_RST;
            location <= `DEAC_LOCATION_RST;
            rd_start <= 1'b0;
            permit <= 1'b0; // R8
            abort <= 1'b0;
            done <= 1'b0;
            arm <= ARM_NONE;
            arm_cnt <= 32'h00000000;
            pstate <= PS_IDLE;
            pcnt <= 32'h00000000;
            pwrt_cnt <= 32'h00000000; // R20
            prog_q <= 8'h00;
        end else begin
            data_byte <= next_data_byte;
            location <= next_location;
            rd_start <= next_rd_start;
            permit <= next_permit;
            abort <= next_abort;
            done <= next_done;
            arm <= next_arm;
            arm_cnt <= next_arm_cnt;
            pstate <= next_pstate;
            pcnt <= next_pcnt;
            pwrt_cnt <= next_pwrt_cnt;
            prog_q <= next_prog_q;
        end
    end

    deac_mem #(
        .DW(8),
        .AW(8)
    ) u_array (
        .clk(sys_clk),
        .we(mem_we),
        .waddr(location),
        .wdata(mem_din),
        .raddr_a(location),
        .rdata_a(mem_rdata_a),
        .raddr_b(prog_addr_s),
        .rdata_b(mem_rdata_b)
    );

    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rresp = rresp;
    assign s_axi_rdata = rdata;
    assign prog_rdata = prog_q;
    assign store_done_flag = done;
    assign store_busy = busy;
endmodule : deac_ctrl
`default_nettype wire

// file: verification/deac_ctrl_props.sv
`timescale 1ns/1ns
`default_nettype none
module deac_ctrl_props #(
    parameter int PWRT_CYCLES = 40
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic external_reset_pin,
    input wire logic watchdog_timeout,
    input wire logic brownout_reset,
    input wire logic data_protect,
    input wire logic [7:0] prog_rdata,
    input wire logic store_done_flag,
    input wire logic store_busy
);
    logic [7:0] ar_q;
    logic [5:0] rq_q;
    logic [31:0] pw_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ar_q <= 8'h00;
            rq_q <= 6'h00;
            pw_q <= 32'h0;
        end else begin
            if (s_axi_arvalid && s_axi_arready)
                ar_q <= s_axi_araddr;
            rq_q <= {rq_q[4:0],
                external_reset_pin | watchdog_timeout | brownout_reset};
            if (pw_q < 32'(PWRT_CYCLES))
                pw_q <= pw_q + 32'h1;
        end
    end
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_start;
        $rose(store_busy) && rq_q == 6'h00;
    endsequence
    property p_busy_hold;
        s_start |-> (store_busy || rq_q != 6'h00)[*6];
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("write cycle ended early");
    property p_busy_end;
        s_start |-> ##[1:12] !store_busy;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("write cycle did not end");
    property p_done_set;
        $fell(store_busy) && rq_q == 6'h00 |-> store_done_flag;
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("done flag not set at write end");
    property p_done_clr;
        $fell(store_done_flag) |-> $past(s_axi_wvalid && !s_axi_wdata[7]);
    endproperty
    a_done_clr: assert property (p_done_clr)
        else $error("done flag dropped without clear");
    property p_start_cause;
        $rose(store_busy) |-> $past(s_axi_wvalid && s_axi_wdata[1]);
    endproperty
    a_start_cause: assert property (p_start_cause)
        else $error("write began without start bit");
    property p_ctl_zero;
        s_axi_rvalid && ar_q == 8'h08 |-> s_axi_rdata[31:4] == 28'h0;
    endproperty
    a_ctl_zero: assert property (p_ctl_zero)
        else $error("control upper bits not zero");
    property p_unlock_zero;
        s_axi_rvalid && ar_q == 8'h0c |-> s_axi_rdata == 32'h0;
    endproperty
    a_unlock_zero: assert property (p_unlock_zero)
        else $error("unlock port read not zero");
    property p_prot;
        data_protect[*6] |-> prog_rdata == 8'h00;
    endproperty
    a_prot: assert property (p_prot)
        else $error("programmer read not zero when protected");
    property p_pwrt;
        $rose(store_busy) |-> pw_q >= 32'(PWRT_CYCLES);
    endproperty
    a_pwrt: assert property (p_pwrt)
        else $error("write began during power-up time");
endmodule : deac_ctrl_props
bind deac_ctrl deac_ctrl_props #(.PWRT_CYCLES(PWRT_CYCLES)) u_props (
    .sys_clk(sys_clk), .rst(rst), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
    .external_reset_pin(external_reset_pin),
    .watchdog_timeout(watchdog_timeout), .brownout_reset(brownout_reset),
    .data_protect(data_protect), .prog_rdata(prog_rdata),
    .store_done_flag(store_done_flag), .store_busy(store_busy));
`default_nettype wire

// file: verification/deac_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module deac_cpu_model (
    input wire logic sys_clk,
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic [1:0] bresp,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    output var logic [7:0] awaddr,
    output var logic awvalid,
    output var logic [31:0] wdata,
    output var logic [3:0] wstrb,
    output var logic wvalid,
    output var logic bready,
    output var logic [7:0] araddr,
    output var logic arvalid,
    output var logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
        wstrb = 4'h1;
    end
    // one register write at a time, in program order
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      output logic [1:0] r);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~awaddr;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~wdata;
            end
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~araddr;
            end
        end
    endtask : rd
endmodule : deac_cpu_model
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int PWRT = 40;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr, araddr, prog_rdata;
    logic [7:0] prog_addr = 8'h00;
    logic [31:0] wdata, rdata, rv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, done, busy;
    logic [2:0] rq = 3'b000;
    logic prot = 1'b0;
    logic [7:0] ta [2] = '{8'h00, 8'hff};
    logic [7:0] td [2] = '{8'h3c, 8'hc3};
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    always #5 sys_clk = ~sys_clk;
    deac_cpu_model u_cpu (.sys_clk(sys_clk), .awready(awready),
        .wready(wready), .bvalid(bvalid), .bresp(bresp), .arready(arready),
        .rvalid(rvalid), .rdata(rdata), .rresp(rresp), .awaddr(awaddr),
        .awvalid(awvalid), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .rready(rready));
    deac_ctrl #(.PWRT_CYCLES(PWRT), .PROG_CYCLES(8), .UNLOCK_WINDOW(16))
    u_dut (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .external_reset_pin(rq[0]),
        .watchdog_timeout(rq[1]), .brownout_reset(rq[2]),
        .data_protect(prot), .prog_addr(prog_addr),
        .prog_rdata(prog_rdata), .store_done_flag(done),
        .store_busy(busy));
    task automatic report_and_stop;
        if (n_mismatch == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        u_cpu.wr(a, d, r);
        chk({6'h0, r}, 8'h00);
    endtask : w
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        u_cpu.rd(a, rv, r);
        chk(rv[7:0], exp);
        chk({6'h0, r}, 8'h00);
    endtask : rc
    task automatic start(input logic [7:0] a, input logic [7:0] d);
        w(8'h04, a);
        w(8'h00, d);
        w(8'h08, 8'h04);
        w(8'h0c, 8'h55);
        w(8'h0c, 8'haa);
        w(8'h08, 8'h06);
    endtask : start
    task automatic wait_idle;
        for (int i = 0; i < 50 && busy !== 1'b0; i++)
            @(posedge sys_clk);
        chk({7'h0, busy}, 8'h00);
    endtask : wait_idle
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        rc(8'h00, 8'h00);
        rc(8'h04, 8'h00);
        rc(8'h08, 8'h00);
        rc(8'h0c, 8'h00);
        rc(8'h10, 8'h00);
        start(8'h20, 8'h11);
        chk({7'h0, busy}, 8'h00);
        u_cpu.wr(8'h14, 8'hff, r);
        chk({6'h0, r}, 8'h02);
        u_cpu.rd(8'h14, rv, r);
        chk(rv[7:0], 8'h00);
        chk({6'h0, r}, 8'h02);
        repeat (PWRT) @(posedge sys_clk);
        rc(8'h08, 8'h04);
        for (int k = 0; k < 2; k++) begin
            start(ta[k], td[k]);
            rc(8'h08, 8'h06);
            wait_idle();
            chk({7'h0, done}, 8'h01);
            rc(8'h10, 8'h80);
            rc(8'h08, 8'h04);
            w(8'h10, 8'h00);
            rc(8'h10, 8'h00);
        end
        for (int k = 0; k < 2; k++) begin
            w(8'h04, ta[k]);
            w(8'h00, 8'h5a);
            w(8'h08, 8'h05);
            rc(8'h00, td[k]);
            rc(8'h00, td[k]);
            rc(8'h08, 8'h04);
        end
        w(8'h08, 8'h00);
        w(8'h0c, 8'h55);
        w(8'h0c, 8'haa);
        w(8'h08, 8'h02);
        chk({7'h0, busy}, 8'h00);
        rc(8'h08, 8'h00);
        w(8'h08, 8'h04);
        w(8'h0c, 8'h55);
        w(8'h00, 8'h77);
        w(8'h0c, 8'haa);
        w(8'h08, 8'h06);
        chk({7'h0, busy}, 8'h00);
        prot <= 1'b1;
        prog_addr <= 8'hff;
        repeat (8) @(posedge sys_clk);
        chk(prog_rdata, 8'h00);
        w(8'h04, 8'hff);
        w(8'h08, 8'h05);
        rc(8'h00, 8'hc3);
        prot <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk(prog_rdata, 8'hc3);
        for (int k = 0; k < 3; k++) begin
            start(8'h40, 8'h99);
            repeat (2) @(posedge sys_clk);
            rq[k] <= 1'b1;
            repeat (4) @(posedge sys_clk);
            rq <= 3'b000;
            wait_idle();
            rc(8'h08, 8'h08);
            rc(8'h00, 8'h00);
            rc(8'h04, 8'h00);
        end
        start(8'h41, 8'h12);
        w(8'h08, 8'h08);
        chk({7'h0, busy}, 8'h01);
        wait_idle();
        rc(8'h08, 8'h00);
        w(8'h00, 8'h00);
        w(8'h08, 8'h01);
        rc(8'h00, 8'h12);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
